//--- hw/efi_pkg.sv
// Constants and state types of the event flag and interrupt enable logic
`default_nettype none

package efi_pkg;

  // Register offsets
  localparam logic [7:0] EFI_MAIN_EN_OFS   = 8'h04;
  localparam logic [7:0] EFI_SEC_EN_OFS    = 8'h05;
  localparam logic [7:0] EFI_MAIN_FLAG_OFS = 8'h06;
  localparam logic [7:0] EFI_CHK_FLAG_OFS  = 8'h07;

  // Reset values
  localparam logic [7:0] EFI_MAIN_EN_RST   = 8'h00;
  localparam logic [7:0] EFI_SEC_EN_RST    = 8'h00;
  localparam logic [7:0] EFI_FLAG_RST      = 8'h00;

  // Implemented bits of each register
  localparam logic [7:0] EFI_MAIN_MASK     = 8'hF3;
  localparam logic [7:0] EFI_CHK_MASK      = 8'h1C;

  // Main flag and main enable bit positions
  localparam int EFI_LOCK_LOST_BIT  = 7;
  localparam int EFI_LOCKED_BIT     = 6;
  localparam int EFI_SYNC_LOST_BIT  = 5;
  localparam int EFI_SYNC_LOCK_BIT  = 4;
  localparam int EFI_WARN1_BIT      = 1;
  localparam int EFI_WARN2_BIT      = 0;

  // Pattern check flag and secondary enable bit positions
  localparam int EFI_AVG_PASS_BIT   = 4;
  localparam int EFI_AVG_FAIL_BIT   = 3;
  localparam int EFI_SMP_FAIL_BIT   = 2;

  // Pointer distances that raise the buffer warnings
  localparam int EFI_WARN1_DIST     = 1;
  localparam int EFI_WARN2_DIST     = 2;

  // Counts
  localparam int EFI_SYNC_PERIODS   = 4;
  localparam int EFI_GOOD_PAIRS     = 8;

  typedef struct packed {
    logic [7:0] main_en;
    logic [7:0] sec_en;
    logic [7:0] main_flags;
    logic [7:0] chk_flags;
    logic       pll_seen;
    logic       sync_seen;
    logic [7:0] rdata;
    logic       irq;
  } efi_state_t;

endpackage

`default_nettype wire

//--- hw/efi_run_counter.sv
// Counter of consecutive qualifying events with a break input
`default_nettype none

module efi_run_counter
  import efi_pkg::*;
#(
  parameter int RUN_LEN = EFI_GOOD_PAIRS
)
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  // Events
  input  wire logic tick_i,
  input  wire logic break_i,
  // Results
  output logic      done_o,
  output logic      hit_o
);

  localparam int CW = $clog2(RUN_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(RUN_LEN);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
    logic          hit;
  } efi_run_state_t;

  efi_run_state_t st_q;
  efi_run_state_t st_d;

  always_comb
  begin
    st_d     = st_q;
    st_d.hit = 1'b0;
    // Break wins over a tick in the same cycle
    if (break_i)
    begin
      st_d.cnt = '0;
    end
    else if (tick_i && (st_q.cnt != LAST))
    begin
      st_d.cnt = st_q.cnt + CW'(1);
      st_d.hit = (st_q.cnt + CW'(1)) == LAST;
    end
    st_d.done = st_d.cnt == LAST;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign done_o = st_q.done;
  assign hit_o  = st_q.hit;

endmodule

`default_nettype wire

//--- hw/efi_event_flags.sv
// Event flags, interrupt enables and interrupt request of the converter
// Notes on behaviour
// - Secondary enable bit 4 lets the averaged check pass raise the interrupt.
// - Secondary enable bit 3 lets the averaged check fail raise the interrupt.
// - Secondary enable bit 2 lets the sample check fail raise the interrupt.
// - Main flag bit 7 latches when a locked clock multiplier loses lock.
// - Main flag bit 6 latches while the clock multiplier is locked.
// - Main flag bit 5 latches when aligned sync logic loses alignment.
// - Main flag bit 4 latches on alignment after consecutive periods without phase change.
// - Main flag bit 1 sets when buffer pointer distance is one.
// - Main flag bit 0 sets when buffer pointer distance is two.
// - A flag other than pattern flag bit 3 clears only when its bit is written with one.
// - Pattern flag bit 4 latches when averaged data matches expected values.
// - Pattern flag bit 3 latches on mismatch, clears after eight good pairs.
// - Main enable bits 7,6,5,4,1,0 enable the matching main flags.
// - Pattern flag bit 2 latches when sample check finds differing data.
`default_nettype none

module efi_event_flags
  import efi_pkg::*;
#(
  parameter int PTR_W        = 3,
  parameter int SYNC_PERIODS = EFI_SYNC_PERIODS,
  parameter int GOOD_PAIRS   = EFI_GOOD_PAIRS
)
(
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  // Register port
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  output logic      [7:0]       reg_rdata_o,
  // Clock multiplier
  input  wire logic             pll_locked_i,
  // Synchronisation logic
  input  wire logic             sync_period_done_i,
  input  wire logic             sync_phase_req_i,
  // Input buffer pointers
  input  wire logic [PTR_W-1:0] fifo_rd_ptr_i,
  input  wire logic [PTR_W-1:0] fifo_wr_ptr_i,
  // Pattern checkers
  input  wire logic             sample_mismatch_i,
  input  wire logic             avg_match_i,
  input  wire logic             avg_mismatch_i,
  input  wire logic             iq_pair_valid_i,
  // Interrupt request
  output logic                  irq_o
);

  function automatic logic sel(input logic [7:0] addr, input logic [7:0] ofs);
    sel = addr == ofs;
  endfunction

  efi_state_t       st_q;
  efi_state_t       st_d;
  logic             sync_aligned;
  logic             good_run_hit;
  logic [PTR_W-1:0] ptr_dist;
  logic [7:0]       main_set;
  logic [7:0]       chk_set;
  logic [7:0]       main_clr;
  logic [7:0]       chk_clr;

  // Alignment after consecutive quiet averaging periods
  efi_run_counter #(
    .RUN_LEN (SYNC_PERIODS)
  ) u_sync_run (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .tick_i    (sync_period_done_i),
    .break_i   (sync_phase_req_i),
    .done_o    (sync_aligned),
    .hit_o     ()
  );

  // Good data pairs following an averaged mismatch
  efi_run_counter #(
    .RUN_LEN (GOOD_PAIRS)
  ) u_pair_run (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .tick_i    (iq_pair_valid_i),
    .break_i   (avg_mismatch_i),
    .done_o    (),
    .hit_o     (good_run_hit)
  );

  assign ptr_dist = fifo_wr_ptr_i - fifo_rd_ptr_i;

  always_comb
  begin
    main_set = 8'h00;
    chk_set  = 8'h00;
    main_clr = 8'h00;
    chk_clr  = 8'h00;
    st_d     = st_q;

    main_set[EFI_LOCK_LOST_BIT] = st_q.pll_seen && !pll_locked_i;
    main_set[EFI_LOCKED_BIT]    = pll_locked_i;
    main_set[EFI_SYNC_LOST_BIT] = st_q.sync_seen && !sync_aligned;
    main_set[EFI_SYNC_LOCK_BIT] = sync_aligned;
    main_set[EFI_WARN1_BIT]     = ptr_dist == PTR_W'(EFI_WARN1_DIST);
    main_set[EFI_WARN2_BIT]     = ptr_dist == PTR_W'(EFI_WARN2_DIST);
    chk_set[EFI_AVG_PASS_BIT]   = avg_match_i;
    chk_set[EFI_AVG_FAIL_BIT]   = avg_mismatch_i;
    chk_set[EFI_SMP_FAIL_BIT]   = sample_mismatch_i;

    // Lock history for the loss events
    if (pll_locked_i)
    begin
      st_d.pll_seen = 1'b1;
    end
    else
    begin
      st_d.pll_seen = 1'b0;
    end
    st_d.sync_seen = sync_aligned;

    // Register writes; only implemented bits are stored
    if (reg_wr_i)
    begin
      if (sel(reg_addr_i, EFI_MAIN_EN_OFS))
      begin
        st_d.main_en = reg_wdata_i & EFI_MAIN_MASK;
      end
      else if (sel(reg_addr_i, EFI_SEC_EN_OFS))
      begin
        st_d.sec_en = reg_wdata_i & EFI_CHK_MASK;
      end
      else if (sel(reg_addr_i, EFI_MAIN_FLAG_OFS))
      begin
        main_clr = reg_wdata_i & EFI_MAIN_MASK;
      end
      else if (sel(reg_addr_i, EFI_CHK_FLAG_OFS))
      begin
        chk_clr = reg_wdata_i & EFI_CHK_MASK;
      end
    end

    // Automatic clear after a run of good pairs
    if (good_run_hit)
    begin
      chk_clr[EFI_AVG_FAIL_BIT] = 1'b1;
    end

    // A new event wins over a clear in the same cycle
    st_d.main_flags = (st_q.main_flags & ~main_clr) | main_set;
    st_d.chk_flags  = (st_q.chk_flags & ~chk_clr) | chk_set;

    // Read data
    if (reg_rd_i)
    begin
      if (sel(reg_addr_i, EFI_MAIN_EN_OFS))
      begin
        st_d.rdata = st_q.main_en;
      end
      else if (sel(reg_addr_i, EFI_SEC_EN_OFS))
      begin
        st_d.rdata = st_q.sec_en;
      end
      else if (sel(reg_addr_i, EFI_MAIN_FLAG_OFS))
      begin
        st_d.rdata = st_q.main_flags;
      end
      else if (sel(reg_addr_i, EFI_CHK_FLAG_OFS))
      begin
        st_d.rdata = st_q.chk_flags;
      end
      else
      begin
        st_d.rdata = 8'h00;
      end
    end

    // Request follows the flag and enable pairs of the next state
    st_d.irq = |((st_d.main_flags & st_d.main_en) | (st_d.chk_flags & st_d.sec_en));
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      st_q.main_en    <= EFI_MAIN_EN_RST;
      st_q.sec_en     <= EFI_SEC_EN_RST;
      st_q.main_flags <= EFI_FLAG_RST;
      st_q.chk_flags  <= EFI_FLAG_RST;
      st_q.pll_seen   <= 1'b0;
      st_q.sync_seen  <= 1'b0;
      st_q.rdata      <= 8'h00;
      st_q.irq        <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o = st_q.rdata;
  assign irq_o       = st_q.irq;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  avg_pass_irq_a: assert property (st_q.chk_flags[EFI_AVG_PASS_BIT] && st_q.sec_en[EFI_AVG_PASS_BIT] |-> irq_o)
    else $error("averaged pass with enable did not raise request");

  avg_fail_irq_a: assert property (st_q.chk_flags[EFI_AVG_FAIL_BIT] && st_q.sec_en[EFI_AVG_FAIL_BIT] |-> irq_o)
    else $error("averaged fail with enable did not raise request");

  smp_fail_irq_a: assert property (st_q.chk_flags[EFI_SMP_FAIL_BIT] && st_q.sec_en[EFI_SMP_FAIL_BIT] |-> irq_o)
    else $error("sample fail with enable did not raise request");

  lock_lost_set_a: assert property (pll_locked_i ##1 !pll_locked_i |=> st_q.main_flags[EFI_LOCK_LOST_BIT])
    else $error("lock loss not latched");

  locked_flag_a: assert property (pll_locked_i |=> st_q.main_flags[EFI_LOCKED_BIT])
    else $error("locked flag not set");

  sync_lost_set_a: assert property (sync_aligned ##1 !sync_aligned |=> st_q.main_flags[EFI_SYNC_LOST_BIT])
    else $error("sync loss not latched");

  sync_lock_flag_a: assert property (sync_aligned |=> st_q.main_flags[EFI_SYNC_LOCK_BIT])
    else $error("sync alignment flag not set");

  warn_dist1_a: assert property (ptr_dist == PTR_W'(EFI_WARN1_DIST) |=> st_q.main_flags[EFI_WARN1_BIT])
    else $error("distance one warning missing");

  warn_dist2_a: assert property (ptr_dist == PTR_W'(EFI_WARN2_DIST) |=> st_q.main_flags[EFI_WARN2_BIT])
    else $error("distance two warning missing");

  zero_write_keeps_a: assert property (reg_wr_i && sel(reg_addr_i, EFI_MAIN_FLAG_OFS)
    && reg_wdata_i == 8'h00 |=> st_q.main_flags == ($past(st_q.main_flags) | $past(main_set)))
    else $error("zero write changed a flag");

  one_write_clears_a: assert property (reg_wr_i && sel(reg_addr_i, EFI_CHK_FLAG_OFS)
    && reg_wdata_i[EFI_SMP_FAIL_BIT] && !sample_mismatch_i |=> !st_q.chk_flags[EFI_SMP_FAIL_BIT])
    else $error("one write did not clear flag");

  avg_pass_set_a: assert property (avg_match_i |=> st_q.chk_flags[EFI_AVG_PASS_BIT])
    else $error("averaged pass not latched");

  // Clear lands two edges after the last pair, so one quiet cycle is needed
  avg_fail_auto_a: assert property (avg_mismatch_i ##1 (!avg_mismatch_i && iq_pair_valid_i) [*8]
    ##1 !avg_mismatch_i |=> !st_q.chk_flags[EFI_AVG_FAIL_BIT] || GOOD_PAIRS != 8)
    else $error("averaged fail not cleared after good pairs");

  smp_fail_set_a: assert property (sample_mismatch_i |=> st_q.chk_flags[EFI_SMP_FAIL_BIT])
    else $error("sample fail not latched");

  irq_idle_a: assert property (!irq_o |-> ((st_q.main_flags & st_q.main_en) == 8'h00)
    && ((st_q.chk_flags & st_q.sec_en) == 8'h00))
    else $error("request low while an enabled flag is set");

  irq_busy_a: assert property (irq_o |-> ((st_q.main_flags & st_q.main_en)
    | (st_q.chk_flags & st_q.sec_en)) != 8'h00)
    else $error("request high with no enabled flag");

  main_en_gate_a: assert property (st_q.main_flags[EFI_LOCK_LOST_BIT] && st_q.main_en[EFI_LOCK_LOST_BIT] |-> irq_o)
    else $error("main enable did not pass lock loss");

  // Each implemented main flag reaches the request through its own enable
  for (genvar gi = 0; gi < 8; gi++)
  begin : g_main_gate
    if (EFI_MAIN_MASK[gi])
    begin : g_bit
      main_gate_a: assert property (st_q.main_flags[gi] && st_q.main_en[gi] |-> irq_o)
        else $error("main enable did not pass its flag");
    end
  end

  main_en_write_a: assert property (reg_wr_i && sel(reg_addr_i, EFI_MAIN_EN_OFS)
    |=> st_q.main_en == ($past(reg_wdata_i) & EFI_MAIN_MASK))
    else $error("main enable write not stored");

  sec_en_write_a: assert property (reg_wr_i && sel(reg_addr_i, EFI_SEC_EN_OFS)
    |=> st_q.sec_en == ($past(reg_wdata_i) & EFI_CHK_MASK))
    else $error("secondary enable write not stored");

  // Latched flags stay until a one is written to them; averaged fail also clears after a run of good pairs
  lock_lost_hold_a: assert property (st_q.main_flags[EFI_LOCK_LOST_BIT]
    && !(reg_wr_i && sel(reg_addr_i, EFI_MAIN_FLAG_OFS) && reg_wdata_i[EFI_LOCK_LOST_BIT])
    |=> st_q.main_flags[EFI_LOCK_LOST_BIT])
    else $error("lock loss flag dropped without a clear");

  sync_lost_hold_a: assert property (st_q.main_flags[EFI_SYNC_LOST_BIT]
    && !(reg_wr_i && sel(reg_addr_i, EFI_MAIN_FLAG_OFS) && reg_wdata_i[EFI_SYNC_LOST_BIT])
    |=> st_q.main_flags[EFI_SYNC_LOST_BIT])
    else $error("sync loss flag dropped without a clear");

  avg_pass_hold_a: assert property (st_q.chk_flags[EFI_AVG_PASS_BIT]
    && !(reg_wr_i && sel(reg_addr_i, EFI_CHK_FLAG_OFS) && reg_wdata_i[EFI_AVG_PASS_BIT])
    |=> st_q.chk_flags[EFI_AVG_PASS_BIT])
    else $error("averaged pass flag dropped without a clear");

  smp_fail_hold_a: assert property (st_q.chk_flags[EFI_SMP_FAIL_BIT]
    && !(reg_wr_i && sel(reg_addr_i, EFI_CHK_FLAG_OFS) && reg_wdata_i[EFI_SMP_FAIL_BIT])
    |=> st_q.chk_flags[EFI_SMP_FAIL_BIT])
    else $error("sample fail flag dropped without a clear");

  avg_fail_hold_a: assert property (st_q.chk_flags[EFI_AVG_FAIL_BIT] && !good_run_hit
    && !(reg_wr_i && sel(reg_addr_i, EFI_CHK_FLAG_OFS) && reg_wdata_i[EFI_AVG_FAIL_BIT])
    |=> st_q.chk_flags[EFI_AVG_FAIL_BIT])
    else $error("averaged fail flag dropped early");

  good_run_clear_a: assert property (good_run_hit && !avg_mismatch_i
    |=> !st_q.chk_flags[EFI_AVG_FAIL_BIT])
    else $error("good pair run did not clear averaged fail");

endmodule

`default_nettype wire

//--- test/event_flag_interrupt_logic_bench.sv
// Self-checking bench of the event flag and interrupt enable logic
`default_nettype none

module event_flag_interrupt_logic_bench;
  import efi_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int P_PER = 0;
  localparam int P_PHS = 1;
  localparam int P_SMP = 2;
  localparam int P_AM  = 3;
  localparam int P_AF  = 4;
  localparam int P_IQ  = 5;

  logic       clk_sys_i;
  logic       nrst_i;
  logic       reg_wr_i;
  logic       reg_rd_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic       pll_locked_i;
  logic       sync_period_done_i;
  logic       sync_phase_req_i;
  logic [2:0] fifo_rd_ptr_i;
  logic [2:0] fifo_wr_ptr_i;
  logic       sample_mismatch_i;
  logic       avg_match_i;
  logic       avg_mismatch_i;
  logic       iq_pair_valid_i;
  logic       irq_o;
  int         err_total;
  int         samples_checked;

  efi_event_flags #(.PTR_W(3), .SYNC_PERIODS(EFI_SYNC_PERIODS), .GOOD_PAIRS(EFI_GOOD_PAIRS)) uut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .pll_locked_i(pll_locked_i), .sync_period_done_i(sync_period_done_i),
    .sync_phase_req_i(sync_phase_req_i), .fifo_rd_ptr_i(fifo_rd_ptr_i), .fifo_wr_ptr_i(fifo_wr_ptr_i),
    .sample_mismatch_i(sample_mismatch_i), .avg_match_i(avg_match_i), .avg_mismatch_i(avg_mismatch_i),
    .iq_pair_valid_i(iq_pair_valid_i), .irq_o(irq_o));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // Read data lands one edge after the strobe; judged mid-cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    cmp("reg_rdata_o", exp, reg_rdata_o);
    @(posedge clk_sys_i);
  endtask

  task automatic irq_chk(input logic e);
    @(negedge clk_sys_i);
    cmp("irq_o", {7'h00, e}, {7'h00, irq_o});
    @(posedge clk_sys_i);
  endtask

  task automatic pulse(input int sel, input int n);
    repeat (n)
    begin
      case (sel)
        P_PER: sync_period_done_i <= 1'b1;
        P_PHS: sync_phase_req_i <= 1'b1;
        P_SMP: sample_mismatch_i <= 1'b1;
        P_AM:  avg_match_i <= 1'b1;
        P_AF:  avg_mismatch_i <= 1'b1;
        default: iq_pair_valid_i <= 1'b1;
      endcase
      @(posedge clk_sys_i);
      {sync_period_done_i, sync_phase_req_i, sample_mismatch_i} <= 3'h0;
      {avg_match_i, avg_mismatch_i, iq_pair_valid_i} <= 3'h0;
      @(posedge clk_sys_i);
    end
  endtask

  task automatic t_regs;
    rd_chk(EFI_MAIN_EN_OFS, 8'h00);
    rd_chk(EFI_SEC_EN_OFS, 8'h00);
    wr(EFI_MAIN_EN_OFS, 8'hFF);
    rd_chk(EFI_MAIN_EN_OFS, 8'hF3);
    wr(EFI_SEC_EN_OFS, 8'h1C);
    rd_chk(EFI_SEC_EN_OFS, 8'h1C);
    wr(8'h10, 8'hFF);
    rd_chk(8'h10, 8'h00);
    wr(EFI_MAIN_EN_OFS, 8'h00);
    wr(EFI_SEC_EN_OFS, 8'h00);
  endtask

  task automatic t_pll;
    pll_locked_i <= 1'b1;
    tick(3);
    rd_chk(EFI_MAIN_FLAG_OFS, 8'h40);
    wr(EFI_MAIN_EN_OFS, 8'h80);
    pll_locked_i <= 1'b0;
    tick(2);
    irq_chk(1'b1);
    rd_chk(EFI_MAIN_FLAG_OFS, 8'hC0);
    wr(EFI_MAIN_FLAG_OFS, 8'h00);
    rd_chk(EFI_MAIN_FLAG_OFS, 8'hC0);
    wr(EFI_MAIN_FLAG_OFS, 8'h40);
    rd_chk(EFI_MAIN_FLAG_OFS, 8'h80);
    wr(EFI_MAIN_FLAG_OFS, 8'h80);
    irq_chk(1'b0);
    wr(EFI_MAIN_EN_OFS, 8'h00);
  endtask

  // Distance is taken modulo the pointer range
  task automatic t_fifo;
    fifo_wr_ptr_i <= 3'h1;
    tick(2);
    rd_chk(EFI_MAIN_FLAG_OFS, 8'h02);
    fifo_wr_ptr_i <= 3'h0;
    fifo_rd_ptr_i <= 3'h6;
    tick(2);
    fifo_rd_ptr_i <= 3'h0;
    rd_chk(EFI_MAIN_FLAG_OFS, 8'h03);
    wr(EFI_MAIN_EN_OFS, 8'h01);
    irq_chk(1'b1);
    wr(EFI_MAIN_FLAG_OFS, 8'h03);
    irq_chk(1'b0);
    rd_chk(EFI_MAIN_FLAG_OFS, 8'h00);
    wr(EFI_MAIN_EN_OFS, 8'h00);
  endtask

  task automatic t_sync;
    pulse(P_PER, EFI_SYNC_PERIODS - 1);
    pulse(P_PHS, 1);
    rd_chk(EFI_MAIN_FLAG_OFS, 8'h00);
    pulse(P_PER, EFI_SYNC_PERIODS);
    tick(2);
    rd_chk(EFI_MAIN_FLAG_OFS, 8'h10);
    pulse(P_PHS, 1);
    tick(2);
    rd_chk(EFI_MAIN_FLAG_OFS, 8'h30);
    wr(EFI_MAIN_FLAG_OFS, 8'h30);
    rd_chk(EFI_MAIN_FLAG_OFS, 8'h00);
  endtask

  task automatic t_check;
    pulse(P_AM, 1);
    pulse(P_SMP, 1);
    rd_chk(EFI_CHK_FLAG_OFS, 8'h14);
    wr(EFI_CHK_FLAG_OFS, 8'h14);
    pulse(P_AF, 1);
    pulse(P_IQ, EFI_GOOD_PAIRS - 1);
    rd_chk(EFI_CHK_FLAG_OFS, 8'h08);
    pulse(P_IQ, 1);
    tick(2);
    rd_chk(EFI_CHK_FLAG_OFS, 8'h00);
    // Mismatch then an unbroken run of pairs
    wr(EFI_SEC_EN_OFS, 8'h08);
    avg_mismatch_i <= 1'b1;
    tick(1);
    avg_mismatch_i  <= 1'b0;
    iq_pair_valid_i <= 1'b1;
    irq_chk(1'b1);
    tick(EFI_GOOD_PAIRS - 1);
    iq_pair_valid_i <= 1'b0;
    tick(1);
    irq_chk(1'b0);
    wr(EFI_SEC_EN_OFS, 8'h00);
    rd_chk(EFI_CHK_FLAG_OFS, 8'h00);
  endtask

  // Each pattern flag raises the request only through its own enable
  task automatic t_chk_irq;
    int         bits [3];
    int         sels [3];
    logic [7:0] m;
    bits = '{EFI_AVG_PASS_BIT, EFI_AVG_FAIL_BIT, EFI_SMP_FAIL_BIT};
    sels = '{P_AM, P_AF, P_SMP};
    for (int i = 0; i < 3; i++)
    begin
      m = 8'h01 << bits[i];
      wr(EFI_SEC_EN_OFS, EFI_CHK_MASK ^ m);
      pulse(sels[i], 1);
      irq_chk(1'b0);
      wr(EFI_SEC_EN_OFS, m);
      irq_chk(1'b1);
      wr(EFI_CHK_FLAG_OFS, m);
      irq_chk(1'b0);
    end
    wr(EFI_SEC_EN_OFS, 8'h00);
  endtask

  // Reset in mid-run drops flags, enables and the request
  task automatic t_reset;
    wr(EFI_SEC_EN_OFS, 8'h04);
    pulse(P_SMP, 1);
    irq_chk(1'b1);
    nrst_i <= 1'b0;
    tick(3);
    nrst_i <= 1'b1;
    irq_chk(1'b0);
    rd_chk(EFI_CHK_FLAG_OFS, 8'h00);
    rd_chk(EFI_SEC_EN_OFS, 8'h00);
  endtask

  initial
  begin
    err_total       = 0;
    samples_checked = 0;
    nrst_i          = 1'b0;
    reg_wr_i        = 1'b0;
    reg_rd_i        = 1'b0;
    reg_addr_i      = 8'h00;
    reg_wdata_i     = 8'h00;
    pll_locked_i    = 1'b0;
    fifo_rd_ptr_i   = 3'h0;
    fifo_wr_ptr_i   = 3'h0;
    {sync_period_done_i, sync_phase_req_i, sample_mismatch_i} = 3'h0;
    {avg_match_i, avg_mismatch_i, iq_pair_valid_i} = 3'h0;
    tick(3);
    nrst_i <= 1'b1;
    tick(1);
    irq_chk(1'b0);
    t_regs();
    t_pll();
    t_fifo();
    t_sync();
    t_check();
    t_chk_irq();
    t_reset();
    end_sim();
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    #(3000 * 100);
    err_total++;
    end_sim();
  end

endmodule

`default_nettype wire
